// ===== verilog/dmc_pkg.sv
// Constants for the DDC mode configuration block: register indices,
// field positions, reset values, stage codes and buffer sizing.
// Assumes an APB register port with 32-bit data, one register per word.
`default_nettype none

package dmc_pkg;

  // ---------------------------------------------------------------------
  // Register indices (byte address is four times the index).
  // ---------------------------------------------------------------------
  localparam int          NREG              = 14;
  localparam int          NDDC              = 2;
  localparam logic [11:0] IDX_DDC_SEL       = 12'h200;
  localparam logic [11:0] IDX_CHIP_DEC      = 12'h201;
  localparam logic [11:0] IDX_D0_CTRL       = 12'h310;
  localparam logic [11:0] IDX_D0_ROUTE      = 12'h311;
  localparam logic [11:0] IDX_D0_TUNE_A     = 12'h314;
  localparam logic [11:0] IDX_D0_TUNE_B     = 12'h315;
  localparam logic [11:0] IDX_D0_PHASE_A    = 12'h320;
  localparam logic [11:0] IDX_D0_PHASE_B    = 12'h321;
  localparam logic [11:0] IDX_D1_CTRL       = 12'h330;
  localparam logic [11:0] IDX_D1_ROUTE      = 12'h331;
  localparam logic [11:0] IDX_D1_TUNE_A     = 12'h334;
  localparam logic [11:0] IDX_D1_TUNE_B     = 12'h335;
  localparam logic [11:0] IDX_D1_PHASE_A    = 12'h340;
  localparam logic [11:0] IDX_D1_PHASE_B    = 12'h341;
  localparam logic [11:0] IDX_STATUS        = 12'h3F0;
  localparam logic [11:0] REG_IDX [NREG]    = '{IDX_DDC_SEL, IDX_CHIP_DEC,
    IDX_D0_CTRL, IDX_D0_ROUTE, IDX_D0_TUNE_A, IDX_D0_TUNE_B, IDX_D0_PHASE_A,
    IDX_D0_PHASE_B, IDX_D1_CTRL, IDX_D1_ROUTE, IDX_D1_TUNE_A, IDX_D1_TUNE_B,
    IDX_D1_PHASE_A, IDX_D1_PHASE_B};

  // ---------------------------------------------------------------------
  // Storage slots and reset values.
  // ---------------------------------------------------------------------
  localparam int          SLOT_DDC_SEL      = 0;
  localparam int          SLOT_CHIP_DEC     = 1;
  localparam int          SLOT_DDC_BASE     = 2;
  localparam int          SLOT_STRIDE       = 6;
  localparam int          OFS_CTRL          = 0;
  localparam int          OFS_ROUTE         = 1;
  localparam logic [7:0]  RST_VAL [NREG]    = '{8'h00, 8'h00, 8'h00, 8'h00,
    8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00, 8'h00};

  // ---------------------------------------------------------------------
  // Field positions and codes.
  // ---------------------------------------------------------------------
  localparam int          SEL_CNT_LSB       = 0;
  localparam int          SEL_IONLY_BIT     = 5;
  localparam logic [1:0]  CNT_NONE          = 2'h0;
  localparam int          CTRL_MIX_BIT      = 7;
  localparam int          CTRL_GAIN_BIT     = 6;
  localparam int          CTRL_REAL_BIT     = 3;
  localparam int          CTRL_HB_LSB       = 0;
  localparam logic [1:0]  HB_SEL_X4         = 2'h0;
  localparam logic [1:0]  HB_SEL_X8         = 2'h1;
  localparam logic [1:0]  HB_SEL_X16        = 2'h2;
  localparam logic [1:0]  HB_SEL_X2         = 2'h3;
  localparam int          ROUTE_I_BIT       = 0;
  localparam int          ROUTE_Q_BIT       = 2;
  localparam int          DEC_CODE_W        = 3;
  localparam logic [7:0]  DEC_ONE           = 8'h01;

  // ---------------------------------------------------------------------
  // Status word layout and buffer sizing.
  // ---------------------------------------------------------------------
  localparam int          STS_VCONV_LSB     = 0;
  localparam int          STS_HB0_LSB       = 4;
  localparam int          STS_HB1_LSB       = 8;
  localparam int          STS_MIX_LSB       = 12;
  localparam int          STS_LEVEL_LSB     = 16;
  localparam int          STS_RATIO_LSB     = 24;
  localparam int          FIFO_DEPTH        = 16;
  localparam int          FIFO_MARGIN       = 4;

endpackage

`default_nettype wire

// ===== verilog/dmc_top.sv
// DDC mode configuration: APB register file, per-DDC decode, sample
// routing, gain, chip decimation and a 16-word output buffer.
// Assumes both converter sample streams arrive on clk, already aligned.
//
// Functional notes
// R1: Selection 0x02 enables two DDCs with complex I/Q; four virtual converters.
// R2: Selection 0x22 enables two DDCs, I path only; two virtual converters.
// R3: Chip decimation value 0x02 sets overall output decimation to four.
// R4: Control 0x80: complex mixer, 0 dB, complex output, second+final stages.
// R5: Control 0x89: complex mixer, 0 dB, real output, third+second+final stages.
// R6: Control 0x49: real mixer, 6 dB, real output, third+second+final stages.
// R7: Control 0x40: real mixer, 6 dB, complex output, second+final stages.
// R8: Routing 0x04 takes I from converter A and Q from converter B.
// R9: Routing 0x00 on the first DDC takes I and Q from converter A.
// R10: Routing 0x05 on the second DDC takes I and Q from converter B.
// R11: Software loads first DDC tuning and phase words at 0x314/0x315/0x320/0x321.
// R12: Software loads second DDC tuning and phase words at 0x334/0x335/0x340/0x341.
// R13: The final half-band stage stays active in every configuration.
//
// Added by the designer: the APB interface to the registers.
`timescale 1ns/10ps
`default_nettype none

// -----------------------------------------------------------------------
// Output buffer with a registered head word.
// -----------------------------------------------------------------------
module dmc_fifo #(
  parameter int W     = 64,
  parameter int DEPTH = 16
) (
  input  wire logic                       clk,      // System clock.
  input  wire logic                       nrst,     // Async reset, low.
  input  wire logic                       in_valid, // Word offered.
  output logic                            in_ready, // Room in storage.
  input  wire logic [W-1:0]               in_data,  // Word written.
  output logic                            out_valid,// Head word valid.
  input  wire logic                       out_ready,// Drain accepts.
  output logic [W-1:0]                    out_data, // Head word.
  output logic [$clog2(DEPTH+2)-1:0]      level,    // Words held.
  output logic                            full,     // Storage full.
  output logic                            empty     // Nothing held.
);
  localparam int AW = $clog2(DEPTH);
  localparam int CW = $clog2(DEPTH+1);
  localparam int LW = $clog2(DEPTH+2);

  logic [W-1:0]  mem_r [DEPTH];
  logic [AW-1:0] wr_ptr_r;
  logic [AW-1:0] rd_ptr_r;
  logic [CW-1:0] cnt_r;
  logic          ov_r;
  logic [W-1:0]  od_r;
  wire           push;
  wire           load;

  // Storage is written only with room, and the head reloads when free.
  assign full      = (cnt_r == CW'(DEPTH));
  assign in_ready  = ~full;
  assign push      = in_valid & ~full;
  assign load      = (~ov_r | out_ready) & (cnt_r != '0);
  assign out_valid = ov_r;
  assign out_data  = od_r;
  assign level     = LW'(cnt_r) + LW'(ov_r);
  assign empty     = (level == '0);

  // Pointer and count bookkeeping.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      wr_ptr_r <= '0;
      rd_ptr_r <= '0;
      cnt_r    <= '0;
    end else begin
      wr_ptr_r <= push ? AW'(wr_ptr_r + 1'b1) : wr_ptr_r;
      rd_ptr_r <= load ? AW'(rd_ptr_r + 1'b1) : rd_ptr_r;
      cnt_r    <= cnt_r + CW'(push) - CW'(load);
    end
  end

  // Memory cells carry no reset; pointers, count and head stage are reset.
  always_ff @(posedge clk) begin
    if (push) begin
      mem_r[wr_ptr_r] <= in_data;
    end
  end

  // Registered head word keeps the drain side glitch free.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ov_r <= 1'b0;
      od_r <= '0;
    end else begin
      ov_r <= load | (ov_r & ~out_ready);
      od_r <= load ? mem_r[rd_ptr_r] : od_r;
    end
  end
endmodule // dmc_fifo

// -----------------------------------------------------------------------
// Top level.
// -----------------------------------------------------------------------
module dmc_top #(
  parameter int SW = 16                          // Sample width.
) (
  input  wire logic              clk,            // 100 MHz system clock.
  input  wire logic              nrst,           // Async reset, low.
  input  wire logic              psel,           // APB select.
  input  wire logic              penable,        // APB access phase.
  input  wire logic              pwrite,         // APB write.
  input  wire logic [13:0]       paddr,          // APB byte address.
  input  wire logic [31:0]       pwdata,         // APB write data.
  output logic      [31:0]       prdata,         // APB read data.
  output logic                   pready,         // APB ready.
  output logic                   pslverr,        // APB error.
  input  wire logic [SW-1:0]     adc_a,          // Converter A sample.
  input  wire logic [SW-1:0]     adc_b,          // Converter B sample.
  input  wire logic              adc_valid,      // Sample pair valid.
  output logic                   adc_ready,      // Block accepts samples.
  output logic                   out_valid,      // Output word valid.
  output logic [4*SW-1:0]        out_data,       // {q1,i1,q0,i0}.
  input  wire logic              out_ready       // Sink accepts word.
);
  localparam int LW = $clog2(dmc_pkg::FIFO_DEPTH+2);
  localparam logic [LW-1:0] RDY_LIMIT =
    LW'(dmc_pkg::FIFO_DEPTH + 2 - dmc_pkg::FIFO_MARGIN);

  // ---------------------------------------------------------------------
  // Register file and APB slave.
  // ---------------------------------------------------------------------
  logic [7:0]             regs_r [dmc_pkg::NREG];
  logic [31:0]            prdata_r;
  logic                   pready_r;
  logic                   pslverr_r;
  wire  [11:0]            idx;
  wire  [dmc_pkg::NREG-1:0] slot_match;
  logic [3:0]             slot;
  wire                    hit_any;
  wire                    sts_hit;
  wire                    setup;
  wire                    wr_go;
  wire  [31:0]            rd_word;
  wire  [31:0]            status;

  // Word index of the access; the two low address bits are ignored.
  assign idx     = paddr[13:2];
  assign sts_hit = (idx == dmc_pkg::IDX_STATUS);
  assign hit_any = |slot_match;
  assign setup   = psel & ~penable;
  assign wr_go   = psel & penable & pready_r & pwrite & hit_any;

  genvar k;
  generate
    for (k = 0; k < dmc_pkg::NREG; k++) begin : g_match
      assign slot_match[k] = (idx == dmc_pkg::REG_IDX[k]);
    end
  endgenerate

  // One-hot match turned into a storage slot number.
  always_comb begin
    slot = 4'h0;
    for (int j = 0; j < dmc_pkg::NREG; j++) begin
      if (slot_match[j]) begin
        slot = 4'(j);
      end
    end
  end

  // Unmapped words read as zero; the status word is read only.
  assign rd_word = sts_hit ? status :
                   hit_any ? {24'h00_0000, regs_r[slot]} : 32'h0000_0000;

  // Answer is prepared during setup so pready is high in the access cycle.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      pready_r  <= 1'b0;
      prdata_r  <= 32'h0000_0000;
      pslverr_r <= 1'b0;
    end else begin
      pready_r  <= setup;
      prdata_r  <= (setup & ~pwrite) ? rd_word : 32'h0000_0000;
      pslverr_r <= setup & ~(hit_any | (sts_hit & ~pwrite));
    end
  end

  // Configuration storage, tuning and phase words included.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      for (int j = 0; j < dmc_pkg::NREG; j++) begin
        regs_r[j] <= dmc_pkg::RST_VAL[j];
      end
    end else begin
      for (int j = 0; j < dmc_pkg::NREG; j++) begin
        if (wr_go && slot_match[j]) begin
          regs_r[j] <= pwdata[7:0];     // [R11] [R12]
        end
      end
    end
  end

  assign prdata  = prdata_r;
  assign pready  = pready_r;
  assign pslverr = pslverr_r;

  // ---------------------------------------------------------------------
  // Chip level decode.
  // ---------------------------------------------------------------------
  wire [7:0] sel_reg;
  wire [7:0] dec_reg;
  wire [1:0] ddc_cnt;
  wire       i_only;
  wire [7:0] ratio;
  wire [3:0] vconv;

  assign sel_reg = regs_r[dmc_pkg::SLOT_DDC_SEL];
  assign dec_reg = regs_r[dmc_pkg::SLOT_CHIP_DEC];
  assign ddc_cnt = sel_reg[dmc_pkg::SEL_CNT_LSB +: 2];       // [R1] [R2]
  assign i_only  = sel_reg[dmc_pkg::SEL_IONLY_BIT];         // [R2]
  // Ratio is two to the power of the code, so 0x02 gives four.
  assign ratio   = dmc_pkg::DEC_ONE << dec_reg[dmc_pkg::DEC_CODE_W-1:0]; // [R3]
  // Virtual converters: two to the power of (DDC count - 1), so count 3 gives four; doubled unless I-only mode is selected.
  assign vconv   = (ddc_cnt == dmc_pkg::CNT_NONE) ? 4'h0 :
                   (4'h1 << (ddc_cnt - 2'h1)) << (i_only ? 1'b0 : 1'b1); // [R1] [R2]

  // ---------------------------------------------------------------------
  // Per-DDC decode, routing and gain.
  // ---------------------------------------------------------------------
  wire [2*SW-1:0] ddc_word [dmc_pkg::NDDC];
  wire [3:0]      hb_en    [dmc_pkg::NDDC];
  wire            mix_cplx [dmc_pkg::NDDC];

  generate
    for (k = 0; k < dmc_pkg::NDDC; k++) begin : g_ddc
      localparam int BASE = dmc_pkg::SLOT_DDC_BASE + k*dmc_pkg::SLOT_STRIDE;
      wire [7:0]    ctrl;
      wire [7:0]    route;
      wire [1:0]    hb_sel;
      wire          en;
      wire          gain6;
      wire          real_out;
      wire          q_keep;
      wire [SW-1:0] i_in;
      wire [SW-1:0] q_in;
      wire [SW-1:0] i_g;
      wire [SW-1:0] q_g;

      assign ctrl     = regs_r[BASE + dmc_pkg::OFS_CTRL];
      assign route    = regs_r[BASE + dmc_pkg::OFS_ROUTE];
      assign en       = (ddc_cnt > 2'(k));                   // [R1] [R2]
      // Bit 7 picks the complex mixer, bit 6 the 6 dB gain.
      assign mix_cplx[k] = ctrl[dmc_pkg::CTRL_MIX_BIT];      // [R4] [R5] [R6] [R7]
      assign gain6    = ctrl[dmc_pkg::CTRL_GAIN_BIT];        // [R4] [R5] [R6] [R7]
      assign real_out = ctrl[dmc_pkg::CTRL_REAL_BIT];        // [R5] [R6]
      assign hb_sel   = ctrl[dmc_pkg::CTRL_HB_LSB +: 2];
      // Stage enables {third..final style order: 3=fourth,2=third,1=second,0=final}.
      assign hb_en[k][0] = 1'b1;                             // [R13]
      assign hb_en[k][1] = (hb_sel != dmc_pkg::HB_SEL_X2);   // [R4] [R7]
      assign hb_en[k][2] = (hb_sel == dmc_pkg::HB_SEL_X8) |
                           (hb_sel == dmc_pkg::HB_SEL_X16);  // [R5] [R6]
      assign hb_en[k][3] = (hb_sel == dmc_pkg::HB_SEL_X16);

      // Input routing: bit 0 steers I, bit 2 steers Q to converter B.
      assign i_in = route[dmc_pkg::ROUTE_I_BIT] ? adc_b : adc_a; // [R8] [R9] [R10]
      // A real mixer has no quadrature input, so its Q branch reuses I.
      assign q_in = ~mix_cplx[k] ? i_in :
                    route[dmc_pkg::ROUTE_Q_BIT] ? adc_b : adc_a; // [R8] [R9] [R10]

      // The 6 dB step doubles the sample and saturates instead of wrapping.
      assign i_g = ~gain6 ? i_in :
                   (i_in[SW-1] != i_in[SW-2]) ? {i_in[SW-1], {(SW-1){~i_in[SW-1]}}} :
                   {i_in[SW-2:0], 1'b0};                     // [R6] [R7]
      assign q_g = ~gain6 ? q_in :
                   (q_in[SW-1] != q_in[SW-2]) ? {q_in[SW-1], {(SW-1){~q_in[SW-1]}}} :
                   {q_in[SW-2:0], 1'b0};                     // [R6] [R7]

      // Q is dropped for real output, chip I-only mode or a disabled DDC.
      assign q_keep      = en & ~real_out & ~i_only;         // [R2] [R5] [R6]
      assign ddc_word[k] = {q_keep ? q_g : {SW{1'b0}}, en ? i_g : {SW{1'b0}}};
    end
  endgenerate

  // ---------------------------------------------------------------------
  // Decimation, staging and output buffer.
  // ---------------------------------------------------------------------
  logic [7:0]      dec_cnt_r;
  logic            stg_valid_r;
  logic [4*SW-1:0] stg_data_r;
  logic            adc_ready_r;
  wire             acc;
  wire             keep;
  wire             fifo_in_ready;
  wire [LW-1:0]    fifo_level;

  assign acc  = adc_valid & adc_ready_r;
  assign keep = acc & (dec_cnt_r == 8'h00);                  // [R3]

  // One accepted sample pair in every ratio is forwarded.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      dec_cnt_r <= 8'h00;
    end else if (acc) begin
      dec_cnt_r <= (dec_cnt_r >= ratio - 8'h01) ? 8'h00 : dec_cnt_r + 8'h01; // [R3]
    end
  end

  // The stage holds its word while the buffer refuses it.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      stg_valid_r <= 1'b0;
      stg_data_r  <= '0;
    end else begin
      stg_valid_r <= keep | (stg_valid_r & ~fifo_in_ready);
      stg_data_r  <= keep ? {ddc_word[1], ddc_word[0]} : stg_data_r;
    end
  end

  // Ready is registered, so it drops with a margin for words in flight.
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      adc_ready_r <= 1'b0;
    end else begin
      adc_ready_r <= (fifo_level < RDY_LIMIT);
    end
  end

  assign adc_ready = adc_ready_r;

  dmc_fifo #(
    .W     (4*SW),
    .DEPTH (dmc_pkg::FIFO_DEPTH)
  ) u_fifo (
    .clk       (clk),
    .nrst      (nrst),
    .in_valid  (stg_valid_r),
    .in_ready  (fifo_in_ready),
    .in_data   (stg_data_r),
    .out_valid (out_valid),
    .out_ready (out_ready),
    .out_data  (out_data),
    .level     (fifo_level),
    .full      (),
    .empty     ()
  );

  // ---------------------------------------------------------------------
  // Status word: decoded configuration and buffer fill.
  // ---------------------------------------------------------------------
  assign status = (32'(vconv)        << dmc_pkg::STS_VCONV_LSB) |
                  (32'(hb_en[0])     << dmc_pkg::STS_HB0_LSB)   |
                  (32'(hb_en[1])     << dmc_pkg::STS_HB1_LSB)   |
                  (32'({mix_cplx[1], mix_cplx[0]}) << dmc_pkg::STS_MIX_LSB) |
                  (32'(fifo_level)   << dmc_pkg::STS_LEVEL_LSB) |
                  (32'(ratio)        << dmc_pkg::STS_RATIO_LSB);
endmodule // dmc_top

`default_nettype wire

// ===== bench/dmc_adc_model.sv
// Behavioural pair of converter cores feeding the block's sample port.
// Assumes the block's clk and nrst; run gates the stream, slow adds gaps.
`timescale 1ns/10ps
`default_nettype none
module dmc_adc_model #(
  parameter int SW = 16
) (
  input  wire logic          clk,       // System clock.
  input  wire logic          nrst,      // Async reset, low.
  input  wire logic          run,       // Stream enable.
  input  wire logic          slow,      // Insert random gaps.
  input  wire logic          adc_ready, // Block accepts pair.
  output logic [SW-1:0]      adc_a,     // Converter A sample.
  output logic [SW-1:0]      adc_b,     // Converter B sample.
  output logic               adc_valid  // Pair offered.
);
  // ---------------------------------------------------------------------
  // Sample source.
  // ---------------------------------------------------------------------
  integer seed = 32'hBE06;

  // A pair is held until taken; idle lines toggle so stale data never passes.
  always @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      adc_valid <= 1'b0;
      adc_a     <= '0;
      adc_b     <= '0;
    end else if (!adc_valid || adc_ready) begin
      if (run && (!slow || $random(seed) % 3 == 0)) begin
        adc_valid <= 1'b1;
        adc_a     <= SW'($random(seed));
        adc_b     <= SW'($random(seed));
      end else begin
        adc_valid <= 1'b0;
        adc_a     <= ~adc_a;
        adc_b     <= ~adc_b;
      end
    end
  end
endmodule // dmc_adc_model
`default_nettype wire

// ===== bench/dmc_top_chk.sv
// Port checker for the DDC mode configuration block.
// Assumes it is bound to dmc_top and sees only that module's ports.
`timescale 1ns/10ps
`default_nettype none
module dmc_top_chk #(
  parameter int SW = 16
) (
  input wire logic          clk,       // System clock.
  input wire logic          nrst,      // Async reset, low.
  input wire logic          psel,      // APB select.
  input wire logic          penable,   // APB access phase.
  input wire logic          pwrite,    // APB write.
  input wire logic [13:0]   paddr,     // APB byte address.
  input wire logic [31:0]   pwdata,    // APB write data.
  input wire logic [31:0]   prdata,    // APB read data.
  input wire logic          pready,    // APB ready.
  input wire logic          pslverr,   // APB error.
  input wire logic [SW-1:0] adc_a,     // Converter A sample.
  input wire logic [SW-1:0] adc_b,     // Converter B sample.
  input wire logic          adc_valid, // Pair offered.
  input wire logic          adc_ready, // Pair accepted.
  input wire logic          out_valid, // Output word valid.
  input wire logic [4*SW-1:0] out_data, // Output word.
  input wire logic          out_ready  // Sink accepts.
);
  // ---------------------------------------------------------------------
  // Register port and output stream.
  // ---------------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  // A setup cycle is answered in the next cycle.
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable && pready;
  endsequence

  chk_apb_zero_wait: assert property (s_setup |=> s_access)
    else $error("access cycle not answered at once");
  chk_ready_single: assert property (pready |=> !pready)
    else $error("ready held longer than one cycle");
  chk_rdata_idle: assert property (!pready |-> prdata == 32'h0)
    else $error("read data outside access cycle");
  chk_err_qual: assert property (pslverr |-> pready)
    else $error("error without ready");
  chk_status_wr_err: assert property (psel && !penable && pwrite &&
    paddr[13:2] == 12'h3F0 |=> pready && pslverr)
    else $error("status write not refused");
  chk_unmapped_err: assert property (psel && !penable &&
    paddr[13:2] < 12'h200 |=> pslverr && prdata == 32'h0)
    else $error("unmapped access not refused");
  chk_upper_zero: assert property (pready && !pslverr &&
    paddr[13:2] != 12'h3F0 |-> prdata[31:8] == 24'h0)
    else $error("upper read bits not zero");
  chk_out_hold: assert property (out_valid && !out_ready |=>
    out_valid && $stable(out_data))
    else $error("output word dropped before taken");
endmodule // dmc_top_chk

bind dmc_top dmc_top_chk #(.SW(SW)) i_chk (.clk(clk), .nrst(nrst), .psel(psel),
  .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_a(adc_a),
  .adc_b(adc_b), .adc_valid(adc_valid), .adc_ready(adc_ready),
  .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
`default_nettype wire

// ===== bench/tb.sv
// Self-checking bench for dmc_top: registers over APB, four DDC setups.
// Assumes the checker is bound in and the converter model is compiled.
`timescale 1ns/10ps
`default_nettype none
module tb;
  logic        clk, nrst, psel, penable, pwrite, pready, pslverr, err;
  logic        adc_valid, adc_ready, out_valid, out_ready, run, slow;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [15:0] adc_a, adc_b;
  logic [63:0] out_data;
  logic [63:0] expq [$];
  logic [7:0]  sel, ctl, rt0, rt1, w;
  int          n_fail, compares, kcnt, k;
  integer      seed;
  logic [7:0]  tsel [4] = '{8'h02, 8'h22, 8'h22, 8'h02};
  logic [7:0]  tctl [4] = '{8'h80, 8'h89, 8'h49, 8'h40};
  logic [7:0]  trt0 [4] = '{8'h04, 8'h04, 8'h00, 8'h00};
  logic [7:0]  trt1 [4] = '{8'h04, 8'h04, 8'h05, 8'h05};

  dmc_top #(.SW(16)) i_dut (.clk(clk), .nrst(nrst), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .adc_a(adc_a),
    .adc_b(adc_b), .adc_valid(adc_valid), .adc_ready(adc_ready),
    .out_valid(out_valid), .out_data(out_data), .out_ready(out_ready));
  dmc_adc_model #(.SW(16)) i_adc (.clk(clk), .nrst(nrst), .run(run),
    .slow(slow), .adc_ready(adc_ready), .adc_a(adc_a), .adc_b(adc_b),
    .adc_valid(adc_valid));

  initial begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  // ---------------------------------------------------------------------
  // Shared tasks and expectations.
  // ---------------------------------------------------------------------
  task automatic wrap_up;
    if (n_fail == 0 && compares > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask

  task automatic chk(input string what, input logic [63:0] exp, input logic [63:0] got);
    compares++;
    if (got !== exp) begin
      n_fail++;
      $display("unexpected %s exp %h got %h", what, exp, got);
    end
  endtask

  // One transfer; the wait is bounded so a silent slave cannot hang the run.
  task automatic apb(input logic wr, input logic [11:0] idx, input logic [31:0] wd);
    int n;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {idx, 2'b00};
    pwdata  <= wd;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    if (pready !== 1'b1) begin
      n_fail++;
      wrap_up();
    end
    rd = prdata;
    err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic rst;
    nrst <= 1'b0;
    repeat (16) @(posedge clk);
    nrst <= 1'b1;
    kcnt = 0;
    @(posedge clk);
  endtask

  function automatic logic [15:0] sat2(logic [15:0] x);
    if (x[15] != x[14]) return x[15] ? 16'h8000 : 16'h7FFF;
    return {x[14:0], 1'b0};
  endfunction

  // Word {q1,i1,q0,i0}; a real mixer feeds its Q branch from the I input.
  function automatic logic [63:0] exp_word(logic [15:0] a, logic [15:0] b);
    logic [63:0] r;
    logic [15:0] i;
    logic [15:0] q;
    logic [7:0]  rt;
    for (int d = 0; d < 2; d++) begin
      rt = d ? rt1 : rt0;
      i = rt[0] ? b : a;
      q = !ctl[7] ? i : (rt[2] ? b : a);
      if (ctl[6]) begin
        i = sat2(i);
        q = sat2(q);
      end
      if (ctl[3] || sel[5]) q = 16'h0000;
      r[32*d +: 32] = {q, i};
    end
    return r;
  endfunction

  function automatic logic [31:0] exp_sts(logic [7:0] s, logic [7:0] c);
    logic [3:0] hb;
    hb = c[0] ? 4'h7 : 4'h3;
    return {8'h04, 8'h00, 2'b00, {2{c[7]}}, hb, hb, s[5] ? 4'h2 : 4'h4};
  endfunction

  // Scoreboard: one pair in four is kept, in order.
  always @(posedge clk) begin
    if (nrst && adc_valid && adc_ready) begin
      if (kcnt % 4 == 0) expq.push_back(exp_word(adc_a, adc_b));
      kcnt++;
    end
    if (nrst && out_valid === 1'b1 && out_ready) begin
      if (expq.size() == 0) chk("spare word", 64'h0, 64'h1);
      else chk("out_data", expq.pop_front(), out_data);
    end
  end

  // ---------------------------------------------------------------------
  // Main sequence.
  // ---------------------------------------------------------------------
  initial begin
    {nrst, psel, penable, pwrite, out_ready, run, slow} = 7'h00;
    paddr = 14'h0000;
    pwdata = 32'h0;
    {sel, ctl, rt0, rt1} = 32'h0;
    n_fail = 0;
    compares = 0;
    seed = 32'hBE06;
    rst();
    foreach (dmc_pkg::REG_IDX[j]) begin
      apb(1'b0, dmc_pkg::REG_IDX[j], 32'h0);
      chk("reset value", 64'h0, rd);
      w = 8'($random(seed));
      apb(1'b1, dmc_pkg::REG_IDX[j], {24'($random(seed)), w});
      apb(1'b0, dmc_pkg::REG_IDX[j], 32'h0);
      chk("readback", {56'h0, w}, rd);
    end
    apb(1'b0, 12'h001, 32'h0);
    chk("unmapped error", 64'h1, err);
    apb(1'b1, dmc_pkg::IDX_STATUS, 32'hFF);
    chk("status write error", 64'h1, err);
    for (int c = 0; c < 4; c++) begin
      rst();
      sel = tsel[c];
      ctl = tctl[c];
      rt0 = trt0[c];
      rt1 = trt1[c];
      apb(1'b1, dmc_pkg::IDX_DDC_SEL, sel);
      apb(1'b1, dmc_pkg::IDX_CHIP_DEC, 32'h02);
      apb(1'b1, dmc_pkg::IDX_D0_CTRL, ctl);
      apb(1'b1, dmc_pkg::IDX_D1_CTRL, ctl);
      apb(1'b1, dmc_pkg::IDX_D0_ROUTE, rt0);
      apb(1'b1, dmc_pkg::IDX_D1_ROUTE, rt1);
      apb(1'b0, dmc_pkg::IDX_STATUS, 32'h0);
      chk("status", exp_sts(sel, ctl), rd);
      slow      <= 1'(c);
      run       <= 1'b1;
      out_ready <= 1'b0;
      if (c == 0) begin
        repeat (120) @(posedge clk);
        chk("refused when full", 64'h0, adc_ready);
      end
      repeat (300) begin
        @(posedge clk);
        out_ready <= 1'($random(seed));
      end
      run       <= 1'b0;
      out_ready <= 1'b1;
      k = 0;
      while ((expq.size() != 0 || adc_valid) && k < 200) begin
        @(posedge clk);
        k++;
      end
      chk("drained", 64'h0, 64'(expq.size() + adc_valid));
      if (expq.size() != 0 || adc_valid) wrap_up();
      chk("pairs taken", 64'h1, 64'(kcnt > 8));
    end
    wrap_up();
  end
endmodule // tb
`default_nettype wire
